// ---- common/bififo_pkg.sv ----
// constants, types and timing mode of the bidirectional queue port control
package bififo_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int DATA_WIDTH = 36;
    localparam int QUEUE_DEPTH = 256;
    localparam int SIDE_COUNT = 2;
    localparam int SIDE_A = 0;
    localparam int SIDE_B = 1;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic RESET_FLAG = 1'b0;
    localparam logic RESET_VALID = 1'b0;

    // ------------------------------------------------------------
    // timing mode
    // ------------------------------------------------------------
    typedef enum logic {MODE_STANDARD, MODE_FALL_THROUGH} timing_mode_t;

endpackage

// ---- common/queue_if.sv ----
// handshake bundle between the port control and one queue store
`timescale 1ns/10ps
interface queue_if #(
    parameter int WIDTH = bififo_pkg::DATA_WIDTH
);
    logic push;
    logic [WIDTH-1:0] push_data;
    logic in_ready;
    logic pop;
    logic [WIDTH-1:0] head;
    logic out_valid;

    // filling side, draining side, and the store itself
    modport fill (output push, output push_data, input in_ready);
    modport drain (output pop, input head, input out_valid);
    modport store (input push, input push_data, output in_ready,
        input pop, output head, output out_valid);
endinterface

// ---- logic/bififo_queue.sv ----
// one-direction queue store with valid and ready on both sides
`timescale 1ns/10ps
module bififo_queue #(
    parameter int WIDTH = bififo_pkg::DATA_WIDTH,
    parameter int DEPTH = bififo_pkg::QUEUE_DEPTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    queue_if.store link
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    // ------------------------------------------------------------
    // handshake decode
    // ------------------------------------------------------------
    wire take = link.push & link.in_ready;
    wire give = link.pop & link.out_valid;
    assign link.in_ready = (count != (AW + 1)'(DEPTH));
    assign link.out_valid = (count != '0);
    assign link.head = mem[rd_ptr];

    // pointer advance with wrap at any depth
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // storage writes, no reset needed
    always_ff @(posedge core_clk) begin
        if (take) begin
            mem[wr_ptr] <= link.push_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (take) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (give) begin
                rd_ptr <= bump(rd_ptr);
            end
            count <= count + (AW + 1)'(take) - (AW + 1)'(give);
        end
    end
endmodule

// ---- logic/bififo_port_ctrl.sv ----
// port access control and status flags of a two-port bidirectional queue
`timescale 1ns/10ps
module bififo_port_ctrl #(
    parameter int WIDTH = bififo_pkg::DATA_WIDTH,
    parameter int DEPTH = bififo_pkg::QUEUE_DEPTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic fall_through_timing_select,
    input wire logic side_a_clock,
    input wire logic side_a_select_n,
    input wire logic side_a_enable,
    input wire logic side_a_write,
    input wire logic [WIDTH-1:0] side_a_data_in,
    output logic [WIDTH-1:0] side_a_data_out,
    output logic side_a_data_oe,
    output logic side_a_empty_or_out_ready,
    output logic side_a_full_or_in_ready,
    input wire logic side_b_clock,
    input wire logic side_b_select_n,
    input wire logic side_b_enable,
    input wire logic side_b_write,
    input wire logic [WIDTH-1:0] side_b_data_in,
    output logic [WIDTH-1:0] side_b_data_out,
    output logic side_b_data_oe,
    output logic side_b_empty_or_out_ready,
    output logic side_b_full_or_in_ready
);
    localparam int N = bififo_pkg::SIDE_COUNT;

    bififo_pkg::timing_mode_t mode;

    // per-side views of the pins, index 0 is side A and 1 is side B
    logic [N-1:0] clk_pin;
    logic [N-1:0] sel_n;
    logic [N-1:0] ena;
    logic [N-1:0] wr;
    logic [WIDTH-1:0] din [N];
    logic [WIDTH-1:0] dout [N];
    logic [N-1:0] oe;
    logic [N-1:0] empty_flag;
    logic [N-1:0] full_flag;

    // queue s carries words written on side s to the other side
    queue_if #(.WIDTH(WIDTH)) q_link [N] ();

    // ------------------------------------------------------------
    // empty / output-ready decode
    // ------------------------------------------------------------
    // active-low empty in standard mode, active-high ready otherwise
    function automatic logic empty_or_ready(
        input bififo_pkg::timing_mode_t m,
        input logic queue_has_data,
        input logic word_presented
    );
        if (m == bififo_pkg::MODE_STANDARD) begin
            empty_or_ready = queue_has_data;
        end else begin
            empty_or_ready = word_presented;
        end
    endfunction

    // ------------------------------------------------------------
    // pin mapping
    // ------------------------------------------------------------
    assign clk_pin = {side_b_clock, side_a_clock};
    assign sel_n = {side_b_select_n, side_a_select_n};
    assign ena = {side_b_enable, side_a_enable};
    assign wr = {side_b_write, side_a_write};
    assign din[bififo_pkg::SIDE_A] = side_a_data_in;
    assign din[bififo_pkg::SIDE_B] = side_b_data_in;
    assign side_a_data_out = dout[bififo_pkg::SIDE_A];
    assign side_b_data_out = dout[bififo_pkg::SIDE_B];
    assign side_a_data_oe = oe[bififo_pkg::SIDE_A];
    assign side_b_data_oe = oe[bififo_pkg::SIDE_B];
    assign side_a_empty_or_out_ready = empty_flag[bififo_pkg::SIDE_A];
    assign side_b_empty_or_out_ready = empty_flag[bififo_pkg::SIDE_B];
    assign side_a_full_or_in_ready = full_flag[bififo_pkg::SIDE_A];
    assign side_b_full_or_in_ready = full_flag[bififo_pkg::SIDE_B];

    // ------------------------------------------------------------
    // timing mode capture
    // ------------------------------------------------------------
    // level caught while reset is held, then kept for operation
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode <= fall_through_timing_select ? bififo_pkg::MODE_STANDARD
                : bififo_pkg::MODE_FALL_THROUGH;
        end
    end

    // ------------------------------------------------------------
    // queue stores
    // ------------------------------------------------------------
    genvar s;
    generate
        for (s = 0; s < N; s++) begin : g_side
            localparam int OTHER = N - 1 - s;

            logic clk_prev;
            logic edge_seen;
            logic edge_late;
            logic presented;
            logic [WIDTH-1:0] out_word;

            bififo_queue #(
                .WIDTH(WIDTH),
                .DEPTH(DEPTH)
            ) u_queue (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .link(q_link[s].store)
            );

            // rising edge of this side's clock pin
            wire side_edge = clk_pin[s] & ~clk_prev;
            // transfer qualified by select low and enable high
            wire side_go = side_edge & ~sel_n[s] & ena[s];
            wire write_go = side_go & wr[s];
            wire read_go = side_go & ~wr[s];
            wire src_valid = q_link[OTHER].out_valid;
            // standard: load on a read; fall-through: refill when slot frees
            wire load_std = read_go & src_valid;
            wire load_ft = side_edge & src_valid & (~presented | read_go);
            wire load = (mode == bififo_pkg::MODE_STANDARD) ? load_std : load_ft;
            wire drop_ft = read_go & ~src_valid;

            // writes into the own queue; refused silently while full
            assign q_link[s].push = write_go & q_link[s].in_ready;
            assign q_link[s].push_data = din[s];
            assign q_link[OTHER].pop = load;

            // drive data only while selected and reading
            assign oe[s] = ~sel_n[s] & ~wr[s];
            assign dout[s] = out_word;

            // edge detect and one-cycle delayed flag strobe
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    clk_prev <= 1'b0;
                    edge_late <= 1'b0;
                end else begin
                    clk_prev <= clk_pin[s];
                    edge_late <= side_edge;
                end
            end
            assign edge_seen = edge_late;

            // output register and its presented-word marker
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    out_word <= '0;
                    presented <= bififo_pkg::RESET_VALID;
                end else if (load) begin
                    out_word <= q_link[OTHER].head;
                    presented <= 1'b1;
                end else if (mode == bififo_pkg::MODE_FALL_THROUGH && drop_ft) begin
                    presented <= 1'b0;
                end
            end

            // flags follow this side's clock edge only
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    empty_flag[s] <= bififo_pkg::RESET_FLAG;
                    full_flag[s] <= bififo_pkg::RESET_FLAG;
                end else if (edge_seen) begin
                    empty_flag[s] <= empty_or_ready(mode, src_valid, presented);
                    full_flag[s] <= q_link[s].in_ready;
                end
            end
        end
    endgenerate
endmodule

// ---- tb/side_master.sv ----
// bus master model standing on one side of the queue port
`timescale 1ns/10ps
module side_master (
    input wire logic core_clk,
    output logic side_clock,
    output logic select_n,
    output logic enable,
    output logic write,
    output logic [bififo_pkg::DATA_WIDTH-1:0] data
);
    // idle pins at time zero, clock standing low
    initial begin
        side_clock = 1'b0;
        select_n = 1'b1;
        enable = 1'b0;
        write = 1'b0;
        data = '0;
    end

    // one side clock rise carrying one request, then released
    task automatic xfer(input logic sn, input logic en, input logic wr,
        input logic [bififo_pkg::DATA_WIDTH-1:0] d);
        @(posedge core_clk);
        side_clock <= 1'b1;
        select_n <= sn;
        enable <= en;
        write <= wr;
        data <= d;
        @(posedge core_clk);
        side_clock <= 1'b0;
        select_n <= 1'b1;
        enable <= 1'b0;
        data <= ~d; // released bus stops showing the word
        @(posedge core_clk);
    endtask
endmodule

// ---- tb/bififo_port_ctrl_sva.sv ----
// concurrent checks on the queue port control pins
`timescale 1ns/10ps
module bififo_port_ctrl_sva #(
    parameter int WIDTH = bififo_pkg::DATA_WIDTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic side_a_clock,
    input wire logic side_a_select_n,
    input wire logic side_a_enable,
    input wire logic side_a_write,
    input wire logic [WIDTH-1:0] side_a_data_out,
    input wire logic side_a_data_oe,
    input wire logic side_a_empty_or_out_ready,
    input wire logic side_a_full_or_in_ready,
    input wire logic side_b_clock,
    input wire logic side_b_select_n,
    input wire logic side_b_enable,
    input wire logic side_b_write,
    input wire logic [WIDTH-1:0] side_b_data_out,
    input wire logic side_b_data_oe,
    input wire logic side_b_empty_or_out_ready,
    input wire logic side_b_full_or_in_ready
);
    logic a_prev;
    logic b_prev;
    wire a_edge = side_a_clock & ~a_prev;
    wire b_edge = side_b_clock & ~b_prev;
    wire a_wr = a_edge & ~side_a_select_n & side_a_enable & side_a_write;
    wire b_wr = b_edge & ~side_b_select_n & side_b_enable & side_b_write;

    // side clock history, cleared in reset as in the design
    always_ff @(posedge core_clk) begin
        a_prev <= sys_rst ? 1'b0 : side_a_clock;
        b_prev <= sys_rst ? 1'b0 : side_b_clock;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_a_oe; side_a_data_oe == (!side_a_select_n && !side_a_write); endproperty
    property p_b_oe; side_b_data_oe == (!side_b_select_n && !side_b_write); endproperty
    property p_a_flag;
        ($changed(side_a_empty_or_out_ready) || $changed(side_a_full_or_in_ready))
            |-> $past(a_edge, 2);
    endproperty
    property p_b_flag;
        ($changed(side_b_empty_or_out_ready) || $changed(side_b_full_or_in_ready))
            |-> $past(b_edge, 2);
    endproperty
    property p_a_data; $changed(side_a_data_out) |-> $past(a_edge); endproperty
    property p_b_data; $changed(side_b_data_out) |-> $past(b_edge); endproperty
    property p_a_full; $fell(side_a_full_or_in_ready) |-> $past(a_wr, 2); endproperty
    property p_b_full; $fell(side_b_full_or_in_ready) |-> $past(b_wr, 2); endproperty

    a_a_oe: assert property (p_a_oe) else $error("side a drive wrong");
    a_b_oe: assert property (p_b_oe) else $error("side b drive wrong");
    a_a_flag: assert property (p_a_flag) else $error("side a flag off edge");
    a_b_flag: assert property (p_b_flag) else $error("side b flag off edge");
    a_a_data: assert property (p_a_data) else $error("side a data off edge");
    a_b_data: assert property (p_b_data) else $error("side b data off edge");
    a_a_full: assert property (p_a_full) else $error("side a full no write");
    a_b_full: assert property (p_b_full) else $error("side b full no write");

    c_a_full: cover property ($fell(side_a_full_or_in_ready));
    c_b_full: cover property ($fell(side_b_full_or_in_ready));
    c_b_data: cover property ($changed(side_b_data_out));
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the queue port control
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
    $display("Error %0t mismatch", $time); end end
module testbench;
    localparam int W = bififo_pkg::DATA_WIDTH;
    localparam int D = 4;
    logic core_clk;
    logic sys_rst = 1'b1;
    logic strap = 1'b1;
    int miscompares = 0;
    int check_count = 0;
    wire [1:0] sclk, seln, sen, swr, oe, emp, ful;
    wire [W-1:0] din [2];
    wire [W-1:0] dout [2];

    // clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #100us;
        miscompares++;
        end_sim();
    end

    for (genvar s = 0; s < 2; s++) begin : g
        side_master side_master_i (.core_clk(core_clk), .side_clock(sclk[s]),
            .select_n(seln[s]), .enable(sen[s]), .write(swr[s]), .data(din[s]));
    end

    bififo_port_ctrl #(.DEPTH(D)) bififo_port_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .fall_through_timing_select(strap), .side_a_clock(sclk[0]),
        .side_a_select_n(seln[0]), .side_a_enable(sen[0]), .side_a_write(swr[0]),
        .side_a_data_in(din[0]), .side_a_data_out(dout[0]), .side_a_data_oe(oe[0]),
        .side_a_empty_or_out_ready(emp[0]), .side_a_full_or_in_ready(ful[0]),
        .side_b_clock(sclk[1]), .side_b_select_n(seln[1]), .side_b_enable(sen[1]),
        .side_b_write(swr[1]), .side_b_data_in(din[1]), .side_b_data_out(dout[1]),
        .side_b_data_oe(oe[1]), .side_b_empty_or_out_ready(emp[1]),
        .side_b_full_or_in_ready(ful[1]));

    task automatic end_sim();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (check_count > 0 && miscompares == 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // one side edge through the model of side s, sampled once settled
    task automatic xf(int s, logic sn, logic en, logic wr, logic [W-1:0] d);
        if (s == 0) g[0].side_master_i.xfer(sn, en, wr, d);
        else g[1].side_master_i.xfer(sn, en, wr, d);
        #1;
    endtask

    task automatic rst(logic m);
        @(posedge core_clk);
        strap <= m;
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    // fill the queue from side s until full, drain it from the other side
    task automatic dir(int s, logic std);
        int r;
        r = 1 - s;
        xf(s, 1'b1, 1'b1, 1'b1, 36'h0a5);
        xf(s, 1'b0, 1'b0, 1'b1, 36'h0a6);
        for (int i = 0; i < D; i++) begin
            xf(s, 1'b0, 1'b1, 1'b1, 36'h0a0 + W'(i));
            `CHK(ful[s], i < D - 1)
        end
        xf(s, 1'b0, 1'b1, 1'b1, 36'hbad);
        xf(r, 1'b1, 1'b0, 1'b0, 36'h0);
        `CHK(emp[r], 1'b1)
        `CHK(oe[r], 1'b0)
        for (int i = 0; i < D; i++) begin
            if (!std) `CHK(dout[r], 36'h0a0 + W'(i))
            xf(r, 1'b0, 1'b1, 1'b0, 36'h0);
            if (std) `CHK(dout[r], 36'h0a0 + W'(i))
        end
        `CHK(emp[r], 1'b0)
        xf(s, 1'b1, 1'b0, 1'b0, 36'h0);
        `CHK(ful[s], 1'b1)
    endtask

    initial begin
        for (int m = 1; m >= 0; m--) begin
            rst(m[0]);
            `CHK({emp, ful}, 4'h0)
            dir(0, m[0]);
            dir(1, m[0]);
            $display("test mode %0d done", m);
        end
        end_sim();
    end
endmodule

bind bififo_port_ctrl bififo_port_ctrl_sva #(.WIDTH(WIDTH)) sva_i (.core_clk, .sys_rst,
    .side_a_clock, .side_a_select_n, .side_a_enable, .side_a_write, .side_a_data_out,
    .side_a_data_oe, .side_a_empty_or_out_ready, .side_a_full_or_in_ready,
    .side_b_clock, .side_b_select_n, .side_b_enable, .side_b_write, .side_b_data_out,
    .side_b_data_oe, .side_b_empty_or_out_ready, .side_b_full_or_in_ready);
